// [design/odsl_chan_mem.sv]
// Eight-word channel data register file with a registered read port.
`timescale 1ns/100ps
module odsl_chan_mem
   import odsl_pkg::*;
(
   input  wire logic        mclk_in,      // System clock.
   input  wire logic        rst_n_in,     // Asynchronous reset, low.
   input  wire logic        wr_en_in,     // Write strobe.
   input  wire logic [2:0]  wr_addr_in,   // Channel written.
   input  wire logic [11:0] wr_data_in,   // Code written.
   input  wire logic [2:0]  rd_addr_in,   // Channel read.
   output logic      [11:0] rd_data_out   // Code read, one cycle late.
);

   typedef struct packed {
      logic [7:0][11:0] word;
      logic [11:0]      rd;
   } odsl_mem_type;

   odsl_mem_type m;
   odsl_mem_type next_m;

   // Read returns the word as it stood before a same-cycle write.
   always_comb begin
      next_m    = m;
      next_m.rd = m.word[rd_addr_in];
      if (wr_en_in) begin
         next_m.word[wr_addr_in] = wr_data_in;
      end
   end

   // Power-on contents are code zero, so outputs start at ground.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         m <= '0;
      end else begin
         m <= next_m;
      end
   end

   assign rd_data_out = m.rd;

endmodule

// [design/odsl_loader.sv]
// Serial frame loader and channel control of the octal DAC.
`timescale 1ns/100ps
module odsl_loader
   import odsl_pkg::*;
(
   input  wire logic        mclk_in,                // System clock.
   input  wire logic        rst_n_in,               // Async reset, low.
   input  wire logic        sclk_in,                // Serial link clock.
   input  wire logic        sync_n_in,              // Frame strobe, low.
   input  wire logic        din_in,                 // Serial data in.
   output logic             dout_out,               // Chained data out.
   output logic [47:0]      dac_low_group_code_out, // Codes, ch 1-4.
   output logic [47:0]      dac_high_group_code_out,// Codes, ch 5-8.
   output logic [7:0]       chan_drive_out,         // Channel driven.
   output logic [15:0]      chan_term_out,          // Termination codes.
   output logic             write_through_mode_out, // Mode flag.
   output logic             frame_done_out,         // Frame executed.
   output logic             frame_abort_out         // Frame discarded.
);

   // -----------------------------------------------------------------
   // Link-side state, clocked by the falling serial clock
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [15:0]      shift;
      logic [CNT_W-1:0] count;
      logic             dout;
   } odsl_link_type;

   // -----------------------------------------------------------------
   // System-side state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic             s1;
      logic             s2;
      logic             s3;
      logic [15:0]      w1;
      logic [15:0]      w2;
      logic [CNT_W-1:0] c1;
      logic [CNT_W-1:0] c2;
      logic             wt;
      logic [7:0][11:0] latch;
      logic [7:0]       down;
      logic [7:0]       waking;
      logic [7:0]       drive;
      logic [7:0][1:0]  term;
      logic [8:0]       wake_cnt;
      odsl_state_type   st;
      logic [2:0]       idx;
      logic             pend;
      logic [2:0]       pidx;
      logic [7:0]       mask;
      logic             done;
      logic             abort;
   } odsl_main_type;

   odsl_link_type l;
   odsl_link_type next_l;
   odsl_main_type m;
   odsl_main_type next_m;
   logic          fresh;

   logic          mem_we;
   logic [2:0]    mem_waddr;
   logic [11:0]   mem_wdata;
   logic [2:0]    mem_raddr;
   logic [11:0]   mem_rdata;
   logic [3:0]    cmd;
   logic [11:0]   data;
   logic [7:0]    wake;

   // One-hot select of a channel; nothing in this module calls it.
   function automatic logic [7:0] chan_sel(input logic [2:0] ch);
      logic [7:0] r;
      r     = 8'h00;
      r[ch] = 1'b1;
      return r;
   endfunction

   // -----------------------------------------------------------------
   // Frame start marker
   // -----------------------------------------------------------------
   // The serial clock usually stops between frames, so a high strobe
   // cannot be seen on a clock edge; it presets this flag instead.
   always_ff @(negedge sclk_in or posedge sync_n_in) begin
      if (sync_n_in) begin
         fresh <= 1'b1;                                        // R3
      end else begin
         fresh <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Link shifter
   // -----------------------------------------------------------------
   // Shift on every falling edge with strobe low; the count saturates
   // so that overlong frames keep the last sixteen bits.
   always_comb begin
      next_l = l;
      if (!sync_n_in) begin
         next_l.shift = {l.shift[14:0], din_in};               // R2 R17 R21
         if (fresh) begin
            next_l.count = CNT_FIRST;                          // R1
            next_l.dout  = 1'b0;
         end else begin
            if (l.count != CNT_MAX) begin
               next_l.count = l.count + CNT_FIRST;
            end
            // Chained output starts once sixteen bits are in place.
            if (l.count >= DOUT_START) begin
               next_l.dout = l.shift[15];                      // R8 R20
            end else begin
               next_l.dout = 1'b0;
            end
         end
      end
   end

   always_ff @(negedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // -----------------------------------------------------------------
   // Command decode and channel control
   // -----------------------------------------------------------------
   assign cmd  = m.w2[CMD_MSB:CMD_LSB];
   assign data = m.w2[CODE_BITS-1:0];
   assign wake = data[7:0] & m.down;

   // The shifter is quiet while the strobe is high, so its word and
   // count are stable when the synchronised rising strobe is seen.
   always_comb begin
      next_m       = m;
      mem_we       = 1'b0;
      mem_waddr    = 3'h0;
      mem_wdata    = CODE_RESET;
      mem_raddr    = m.idx;
      next_m.s1    = sync_n_in;
      next_m.s2    = m.s1;
      next_m.s3    = m.s2;
      next_m.w1    = l.shift;
      next_m.w2    = m.w1;
      next_m.c1    = l.count;
      next_m.c2    = m.c1;
      next_m.done  = 1'b0;
      next_m.abort = 1'b0;

      // Recovery timer: waking channels stay undriven until it ends.
      if (m.wake_cnt != 9'h000) begin
         next_m.wake_cnt = m.wake_cnt - WAKE_LAST;
         if (m.wake_cnt == WAKE_LAST) begin
            next_m.waking = 8'h00;                             // R15
         end
      end

      // Update walk copies data registers into output latches.
      case (m.st)
         ST_IDLE: begin
            next_m.pend = 1'b0;
         end
         ST_WALK: begin
            if (m.pend && m.mask[m.pidx]) begin
               next_m.latch[m.pidx] = mem_rdata;               // R15
            end
            next_m.pend = 1'b1;
            next_m.pidx = m.idx;
            if (m.idx == 3'h7) begin
               next_m.st = ST_DRAIN;
            end else begin
               next_m.idx = m.idx + 3'h1;
            end
         end
         ST_DRAIN: begin
            if (m.pend && m.mask[m.pidx]) begin
               next_m.latch[m.pidx] = mem_rdata;
            end
            next_m.pend = 1'b0;
            next_m.st   = ST_IDLE;
         end
         default: begin
            next_m.st   = ST_IDLE;
            next_m.pend = 1'b0;
         end
      endcase

      // Rising strobe: execute a full frame, drop a short one.
      if (m.s2 && !m.s3) begin
         if (m.c2 < EXEC_MIN_EDGES) begin
            next_m.abort = 1'b1;                               // R7
         end else begin
            next_m.done = 1'b1;                                // R5
            if (!cmd[3]) begin
               // Writes land even on powered-down channels.
               mem_we    = 1'b1;                               // R18 R14
               mem_waddr = cmd[2:0];
               mem_wdata = data;                               // R11
               if (m.wt) begin
                  next_m.latch[cmd[2:0]] = data;               // R13
               end
            end else begin
               case (cmd)
                  CMD_REG_ONLY: begin
                     next_m.wt = 1'b0;                         // R19
                  end
                  CMD_WRITE_THRU: begin
                     if (data == CODE_RESET) begin
                        next_m.wt = 1'b1;                      // R19
                     end
                  end
                  CMD_UPDATE: begin
                     // A walk already running is not restarted.
                     if (m.st == ST_IDLE) begin
                        next_m.mask = data[7:0];               // R13
                        next_m.idx  = 3'h0;
                        next_m.pend = 1'b0;
                        next_m.st   = ST_WALK;
                        next_m.down = m.down & ~data[7:0];
                        // A channel brought back up drops its termination.
                        for (int i = 0; i < CHANNELS; i++) begin
                           if (data[i]) begin
                              next_m.term[i] = TERM_NONE;      // R16
                           end
                        end
                        next_m.waking = next_m.waking | wake;
                        if (wake != 8'h00) begin
                           next_m.wake_cnt = WAKE_LOAD;        // R15
                        end
                     end
                  end
                  CMD_TERM_HIZ, CMD_TERM_100K, CMD_TERM_2K5: begin
                     next_m.down   = m.down | data[7:0];
                     next_m.waking = next_m.waking & ~data[7:0];
                     for (int i = 0; i < CHANNELS; i++) begin
                        if (data[i]) begin
                           next_m.term[i] = cmd[1:0];          // R16
                        end
                     end
                  end
                  default: begin
                     next_m.wt = m.wt;
                  end
               endcase
            end
         end
      end

      next_m.drive = ~next_m.down & ~next_m.waking;
   end

   // Power-on state: register-only mode, all channels driven at zero.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         m        <= '0;
         m.s1     <= 1'b1;
         m.s2     <= 1'b1;
         m.s3     <= 1'b1;
         m.wt     <= MODE_RESET;                               // R19
         m.down   <= DOWN_RESET;
         m.drive  <= ~DOWN_RESET;
         m.st     <= ST_IDLE;
      end else begin
         m <= next_m;
      end
   end

   // -----------------------------------------------------------------
   // Channel data registers
   // -----------------------------------------------------------------
   odsl_chan_mem u_mem (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .wr_en_in    (mem_we),
      .wr_addr_in  (mem_waddr),
      .wr_data_in  (mem_wdata),
      .rd_addr_in  (mem_raddr),
      .rd_data_out (mem_rdata)
   );

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Channels split by reference input: low group first four.
   assign dac_low_group_code_out  = m.latch[3:0];              // R12
   assign dac_high_group_code_out = m.latch[7:4];              // R12
   assign chan_drive_out          = m.drive;
   assign chan_term_out           = m.term;
   assign write_through_mode_out  = m.wt;
   assign frame_done_out          = m.done;
   assign frame_abort_out         = m.abort;
   assign dout_out                = l.dout;                    // R20

endmodule

// [design/odsl_pkg.sv]
// Constants, types and timing shared by the octal DAC serial loader.
//
// Operation
// [R1] A frame is sixteen falling clocks, strobe low.
// [R2] Shift serial input on falling edges while low.
// [R3] Host opens each write by lowering strobe.
// [R4] Host keeps strobe fall off clock falling edges.
// [R5] Strobe rise after full frame executes command.
// [R6] Host raises strobe between sixteenth and seventeenth.
// [R7] Early strobe rise aborts and discards bits.
// [R8] Strobe low past seventeenth: input goes out.
// [R9] Host keeps strobe high minimum time between.
// [R10] Host idles strobe high to keep output quiet.
// [R11] Codes are unsigned binary, zero to 4095.
// [R12] Channels 1-4 low reference, 5-8 high.
// [R13] Eight data registers; mode decides output update.
// [R14] Power-down keeps registers and accepts writes.
// [R15] Wake-up waits, then outputs take register values.
// [R16] Powered-down channel shows one of three terminations.
// [R17] MSB first: four address bits, twelve data.
// [R18] Addresses 0000-0111 select channels one to eight.
// [R19] Reset in register-only mode; 1001/1000 switch modes.
// [R20] Serial output comes from shift end, falling edges.
// [R21] Overlong frames act on last sixteen bits.
package odsl_pkg;

   // -----------------------------------------------------------------
   // Frame layout and edge counts
   // -----------------------------------------------------------------
   localparam int         FRAME_BITS     = 16;
   localparam int         CODE_BITS      = 12;
   localparam int         CHANNELS       = 8;
   localparam int         CMD_MSB        = 15;
   localparam int         CMD_LSB        = 12;
   localparam int         CNT_W          = 5;
   localparam logic [4:0] EXEC_MIN_EDGES = 5'h10;
   localparam logic [4:0] DOUT_START     = 5'h10;
   localparam logic [4:0] CNT_MAX        = 5'h1f;
   localparam logic [4:0] CNT_FIRST      = 5'h01;

   // -----------------------------------------------------------------
   // Command codes in the upper four bits
   // -----------------------------------------------------------------
   localparam logic [3:0] CMD_REG_ONLY   = 4'h8;
   localparam logic [3:0] CMD_WRITE_THRU = 4'h9;
   localparam logic [3:0] CMD_UPDATE     = 4'ha;
   localparam logic [3:0] CMD_TERM_HIZ   = 4'hd;
   localparam logic [3:0] CMD_TERM_100K  = 4'he;
   localparam logic [3:0] CMD_TERM_2K5   = 4'hf;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [11:0] CODE_RESET    = 12'h000;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   localparam logic        MODE_RESET    = 1'b0;
   localparam logic [7:0]  DOWN_RESET    = 8'h00;

   // -----------------------------------------------------------------
   // Wake-up recovery time
   // -----------------------------------------------------------------
   localparam int         WAKE_TIME_NS   = 8000;
   localparam int         MCLK_PERIOD_NS = 20;
   localparam int         WAKE_CYCLES    =
      (WAKE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [8:0] WAKE_LOAD      = 9'(WAKE_CYCLES);
   localparam logic [8:0] WAKE_LAST      = 9'h001;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      TERM_NONE = 2'b00,
      TERM_HIZ  = 2'b01,
      TERM_100K = 2'b10,
      TERM_2K5  = 2'b11
   } odsl_term_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WALK  = 2'b01,
      ST_DRAIN = 2'b10
   } odsl_state_type;

endpackage

// [tb/odsl_host.sv]
// Host model that drives command frames onto the loader's link pins.
`timescale 1ns/100ps
module odsl_host (
   output logic      sclk_out,   // Link clock, idles high.
   output logic      sync_n_out, // Frame strobe, low.
   output logic      din_out,    // Serial data.
   input  wire logic dout_in     // Chained data back.
);
   logic [31:0] cap;

   // The clock stands still and the strobe idles high between frames.
   initial begin
      sclk_out = 1'b1;
      sync_n_out = 1'b1;
      din_out = 1'b0;
      cap = 32'h0;
   end

   // Send the low k bits of x msb first; cap gathers the chained bits.
   task automatic send(input logic [31:0] x, input int k);
      sync_n_out = 1'b0;
      cap = 32'h0;
      #2;
      for (int i = k - 1; i >= 0; i--) begin
         din_out = x[i];
         #3 sclk_out = 1'b0;
         #3 sclk_out = 1'b1;
         cap = {cap[30:0], dout_in};
      end
      #2 sync_n_out = 1'b1;
      // A released line flips so that no stale bit can be relied on.
      din_out = ~din_out;
      #20;
   endtask
endmodule

// [tb/odsl_loader_chk.sv]
// Port-level assertions for the octal DAC serial loader.
`timescale 1ns/100ps
module odsl_loader_chk
   import odsl_pkg::*;
(
   input wire logic        mclk_in,                 // System clock.
   input wire logic        rst_n_in,                // Reset, low.
   input wire logic        sclk_in,                 // Link clock.
   input wire logic        sync_n_in,               // Frame strobe.
   input wire logic        din_in,                  // Serial data.
   input wire logic        dout_out,                // Chained data.
   input wire logic [47:0] dac_low_group_code_out,  // Codes 1-4.
   input wire logic [47:0] dac_high_group_code_out, // Codes 5-8.
   input wire logic [7:0]  chan_drive_out,          // Driven flags.
   input wire logic [15:0] chan_term_out,           // Terminations.
   input wire logic        write_through_mode_out,  // Mode flag.
   input wire logic        frame_done_out,          // Done pulse.
   input wire logic        frame_abort_out          // Abort pulse.
);
   logic [4:0]  edges;
   logic [16:0] hist;
   logic [8:0]  since_done;
   logic [7:0]  termd;

   // ----------
   // Helpers
   // ----------
   // Edges in this frame; the strobe clears it at once, not on a clock.
   always_ff @(negedge sclk_in or posedge sync_n_in) begin
      if (sync_n_in) edges <= 5'h00;
      else if (edges != CNT_MAX) edges <= edges + 5'h01;
   end
   // Recent input bits, to predict the chained output.
   always_ff @(negedge sclk_in) hist <= {hist[15:0], din_in};
   // Cycles since the last executed frame, saturating.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) since_done <= 9'h000;
      else if (frame_done_out) since_done <= 9'h000;
      else if (since_done != 9'h1ff) since_done <= since_done + 9'h001;
   end
   // A channel with any termination set.
   always_comb begin
      for (int i = 0; i < 8; i++) termd[i] = |chan_term_out[2*i +: 2];
   end

   // ----------
   // Assertions
   // ----------
   chk_done_pulse: assert property (@(posedge mclk_in)
      disable iff (!rst_n_in) frame_done_out |=> !frame_done_out)
      else $error("done pulse too long");
   chk_abort_pulse: assert property (@(posedge mclk_in)
      disable iff (!rst_n_in) frame_abort_out |=> !frame_abort_out)
      else $error("abort pulse too long");
   chk_rise_answer: assert property (@(posedge mclk_in)
      disable iff (!rst_n_in)
      $rose(sync_n_in) |-> ##[2:7] (frame_done_out || frame_abort_out))
      else $error("strobe rise left unanswered");
   chk_mode_cause: assert property (@(posedge mclk_in)
      disable iff (!rst_n_in)
      $changed(write_through_mode_out) |-> frame_done_out)
      else $error("mode changed without a frame");
   chk_abort_quiet: assert property (@(posedge mclk_in)
      disable iff (!rst_n_in) frame_abort_out |->
      $stable(dac_low_group_code_out) && $stable(write_through_mode_out))
      else $error("aborted frame changed state");
   chk_term_drive: assert property (@(posedge mclk_in)
      disable iff (!rst_n_in) (chan_drive_out & termd) == 8'h00)
      else $error("terminated channel still driven");
   chk_wake_delay: assert property (@(posedge mclk_in)
      disable iff (!rst_n_in)
      |(chan_drive_out & ~$past(chan_drive_out)) |-> since_done >= 9'h186)
      else $error("channel woke too soon");
   chk_dout_quiet: assert property (@(negedge sclk_in)
      disable iff (!rst_n_in)
      !sync_n_in && edges != 5'h00 && edges <= 5'h10 |-> !dout_out)
      else $error("chained output early");
   chk_dout_chain: assert property (@(negedge sclk_in)
      disable iff (!rst_n_in)
      !sync_n_in && edges > 5'h10 |-> dout_out == hist[16])
      else $error("chained output wrong bit");

   cov_done: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      frame_done_out);
   cov_abort: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      frame_abort_out);
   cov_wake: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      $rose(chan_drive_out[0]));
endmodule

bind odsl_loader odsl_loader_chk chk (.mclk_in(mclk_in),
   .rst_n_in(rst_n_in), .sclk_in(sclk_in), .sync_n_in(sync_n_in),
   .din_in(din_in), .dout_out(dout_out),
   .dac_low_group_code_out(dac_low_group_code_out),
   .dac_high_group_code_out(dac_high_group_code_out),
   .chan_drive_out(chan_drive_out), .chan_term_out(chan_term_out),
   .write_through_mode_out(write_through_mode_out),
   .frame_done_out(frame_done_out), .frame_abort_out(frame_abort_out));

// [tb/odsl_loader_test.sv]
// Self-checking bench for the octal DAC serial loader.
`timescale 1ns/100ps
module odsl_loader_test;
   import odsl_pkg::*;
   logic        mclk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        sclk, sync_n, din, dout, write_through_mode, done, abort, mode;
   logic        got_d, got_a;
   logic [47:0] lo, hi;
   logic [7:0]  drive, down;
   logic [15:0] term, term_e;
   logic [11:0] dreg [8];
   logic [11:0] outv [8];
   logic [31:0] w;
   integer      seed = 32'ha289;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          n;

   // System clock; the host makes the link clock only inside frames.
   always #10 mclk_in = ~mclk_in;

   odsl_host host (.sclk_out(sclk), .sync_n_out(sync_n), .din_out(din),
      .dout_in(dout));
   odsl_loader dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .sclk_in(sclk), .sync_n_in(sync_n), .din_in(din), .dout_out(dout),
      .dac_low_group_code_out(lo), .dac_high_group_code_out(hi),
      .chan_drive_out(drive), .chan_term_out(term),
      .write_through_mode_out(write_through_mode), .frame_done_out(done),
      .frame_abort_out(abort));

   // ----------
   // Checking and expectations
   // ----------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // A hung run counts as a failure.
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         conclude;
      end
   end

   function automatic logic [47:0] pack(input int b);
      for (int i = 0; i < 4; i++) pack[i*12 +: 12] = outv[b+i];
   endfunction

   // Update the expected state for one executed command.
   task automatic apply(input logic [15:0] f);
      logic [3:0] c;
      c = f[15:12];
      if (!c[3]) begin
         dreg[c[2:0]] = f[11:0];
         if (mode) outv[c[2:0]] = f[11:0];
      end
      else if (c == CMD_REG_ONLY) mode = 1'b0;
      else if (c == CMD_WRITE_THRU && f[11:0] == 12'h000) mode = 1'b1;
      else if (c == CMD_UPDATE || c >= CMD_TERM_HIZ) begin
         for (int i = 0; i < 8; i++) begin
            if (f[i]) begin
               if (c == CMD_UPDATE) outv[i] = dreg[i];
               down[i] = (c != CMD_UPDATE);
               term_e[2*i +: 2] = (c == CMD_UPDATE) ? 2'b00 : c[1:0];
            end
         end
      end
   endtask

   task automatic expect_all;
      check(lo, pack(0));
      check(hi, pack(4));
      check(write_through_mode, mode);
      check(term, term_e);
      check(drive, 8'(~down));
   endtask

   // Send a frame, then watch for its pulse and the chained bits.
   task automatic frame(input logic [31:0] x, input int k);
      host.send(x, k);
      got_d = 1'b0;
      got_a = 1'b0;
      repeat (16) begin
         @(negedge mclk_in);
         got_d |= done;
         got_a |= abort;
      end
      check({got_d, got_a}, (k >= 16) ? 2'b10 : 2'b01);
      check(host.cap, (k > 16) ? x >> 16 : 32'h0);
      if (k >= 16) apply(x[15:0]);
   endtask

   // ----------
   // Main sequence
   // ----------
   initial begin
      down = 8'h00;
      term_e = 16'h0000;
      mode = 1'b0;
      for (int i = 0; i < 8; i++) begin
         dreg[i] = 12'h000;
         outv[i] = 12'h000;
      end
      repeat (20) @(negedge mclk_in);
      rst_n_in = 1'b1;
      repeat (3) @(negedge mclk_in);
      expect_all;
      // Register-only writes must leave the outputs alone.
      for (int i = 0; i < 8; i++) begin
         frame({17'h0, 3'(i), 12'($random(seed))}, 16);
         expect_all;
      end
      // Refused and inert commands, then update and write-through.
      frame(32'h9001, 16);
      frame(32'hb000, 16);
      frame(32'hc000, 16);
      expect_all;
      frame(32'ha0ff, 16);
      frame(32'h9000, 16);
      expect_all;
      // Random frames of 10 to 24 edges with boundary lengths first.
      for (int i = 0; i < 40; i++) begin
         w = $random(seed);
         n = (i < 3) ? 15 + i : (i < 5) ? 16 : 10 + int'(w[31:28]) % 15;
         w = $random(seed);
         if (i == 3) w[11:0] = 12'hfff;
         if (i == 4) w[11:0] = 12'h000;
         w[15] = 1'b0;
         w = 32'(w & ((33'h1 << n) - 33'h1));
         frame(w, n);
         expect_all;
      end
      // Power down with every termination, write while down, wake up.
      frame(32'hd00f, 16);
      frame(32'he030, 16);
      frame(32'hf0c0, 16);
      expect_all;
      frame(32'h0123, 16);
      frame(32'h8000, 16);
      frame(32'h1456, 16);
      expect_all;
      frame(32'ha0ff, 16);
      check(drive, 8'h00);
      repeat (300) @(negedge mclk_in);
      check(drive, 8'h00);
      repeat (120) @(negedge mclk_in);
      expect_all;
      conclude;
   end
endmodule
